// ---- verilog/interlock_pkg.sv ----
package interlock_pkg;

  // Bus data width
  localparam int unsigned DATA_W = 32;

  // Register byte offsets (low address byte)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;

  // Synchronised pin vector positions
  localparam int unsigned PIN_MODE_A = 0;
  localparam int unsigned PIN_MODE_B = 1;
  localparam int unsigned PIN_STOP = 2;
  localparam int unsigned PIN_DOOR = 3;
  localparam int unsigned PIN_ENABLE = 4;
  localparam int unsigned PIN_MPR = 5;
  localparam int unsigned PIN_PLUG = 6;
  localparam int unsigned PIN_N = 7;

  // Status register fields
  localparam int unsigned STAT_PIN_LSB = 0;
  localparam int unsigned STAT_MODE_LSB = 7;
  localparam int unsigned STAT_OUT_LSB = 10;
  localparam int unsigned STAT_W = 14;

  // Control register fields
  localparam int unsigned CTRL_PERMIT = 0;
  localparam logic CTRL_PERMIT_RST = 1'b0;

  // Event bits, shared by event and mask registers
  localparam int unsigned EVT_ESTOP = 0;
  localparam int unsigned EVT_MODE_FAULT = 1;
  localparam int unsigned EVT_DROP = 2;
  localparam int unsigned EVT_CLOSE = 3;
  localparam int unsigned EVT_N = 4;
  localparam logic [EVT_N-1:0] EVT_RST = 4'h0;
  localparam logic [EVT_N-1:0] MASK_RST = 4'h0;

  // Selected operating mode
  typedef enum logic [2:0] {
    MODE_INVALID = 3'b001,
    MODE_AUTO = 3'b010,
    MODE_MANUAL = 3'b100
  } mode_t;

endpackage

// ---- verilog/robot_safety_interlock.sv ----
// What this block does
// - An open emergency stop drops the contactor on the first clock-enabled edge after it leaves the synchroniser, whatever the other inputs say.
// - Mode contact a closed with contact b open selects automatic mode.
// - Mode contact a open with contact b closed selects manual mode.
// - In automatic mode the pendant enable switch has no effect on any output except its pin bit in the status register read.
// - In automatic mode the contactor closes only with stop closed, door closed and power ready.
// - In manual mode the pendant enable switch is a condition for powering the drive.
// - In manual mode the contactor closes only with stop closed, door open, enable closed and power ready.
// - A pendant connector with neither pendant nor loop plug fitted counts as an emergency stop.
module robot_safety_interlock #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [interlock_pkg::DATA_W-1:0] pwdata,
  output logic [interlock_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Switch and controller inputs, high means contact closed or signal on
  input wire logic mode_contact_a,
  input wire logic mode_contact_b,
  input wire logic stop_pushbutton_closed,
  input wire logic door_interlock_closed,
  input wire logic pendant_enable_closed,
  input wire logic main_power_ready,
  input wire logic pendant_loop_plug_fitted,
  // Interlock outputs
  output logic drive_power_contactors,
  output logic stop_circuit_ready,
  output logic auto_mode,
  // Interrupt
  output logic irq
);
  import interlock_pkg::*;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_ff;
  logic [PIN_N-1:0] sync2_ff;
  logic stop_ok;
  logic stop_ok_prev_ff;
  mode_t mode_ff;
  mode_t nxt_mode;
  logic cond_ok;
  logic nxt_contactor;
  logic nxt_ready;
  logic nxt_auto;
  logic contactor_ff;
  logic ready_ff;
  logic auto_ff;
  logic permit_ff;
  logic [EVT_N-1:0] event_ff;
  logic [EVT_N-1:0] mask_ff;
  logic [EVT_N-1:0] evt_set;
  logic [EVT_N-1:0] evt_clr;
  logic [EVT_N-1:0] nxt_event;
  logic [EVT_N-1:0] nxt_mask;
  logic irq_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [STAT_W-1:0] status_word;
  logic setup_phase;
  logic wr_done;
  logic hit_ctrl;
  logic hit_status;
  logic hit_event;
  logic hit_mask;

  assign pin_raw = {pendant_loop_plug_fitted, main_power_ready, pendant_enable_closed,
                    door_interlock_closed, stop_pushbutton_closed, mode_contact_b,
                    mode_contact_a};

  // Two-stage synchroniser per pin; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else if (ce) begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // A missing pendant and plug breaks the stop chain like a pressed button
  assign stop_ok = sync2_ff[PIN_STOP] & sync2_ff[PIN_PLUG];

  // Mode decode from the two selector contacts
  always_comb begin
    nxt_mode = MODE_INVALID;
    if (sync2_ff[PIN_MODE_A] && !sync2_ff[PIN_MODE_B]) begin
      nxt_mode = MODE_AUTO;
    end else if (!sync2_ff[PIN_MODE_A] && sync2_ff[PIN_MODE_B]) begin
      nxt_mode = MODE_MANUAL;
    end
  end

  // Output decision; every path not listed leaves the drive off
  always_comb begin
    cond_ok = 1'b0;
    case (nxt_mode)
      MODE_AUTO: begin
        // Enable switch deliberately not read here
        cond_ok = stop_ok && sync2_ff[PIN_DOOR];
      end
      MODE_MANUAL: begin
        cond_ok = stop_ok && !sync2_ff[PIN_DOOR] && sync2_ff[PIN_ENABLE];
      end
      default: begin
        cond_ok = 1'b0;
      end
    endcase
    nxt_ready = cond_ok;
    nxt_auto = cond_ok && (nxt_mode == MODE_AUTO);
    // Software can only withhold power, never force it on
    nxt_contactor = cond_ok && sync2_ff[PIN_MPR] && permit_ff && stop_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_INVALID;
    end else if (ce) begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contactor_ff <= 1'b0;
      ready_ff <= 1'b0;
      auto_ff <= 1'b0;
    end else if (ce) begin
      contactor_ff <= nxt_contactor;
      ready_ff <= nxt_ready;
      auto_ff <= nxt_auto;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ok_prev_ff <= 1'b0;
    end else if (ce) begin
      stop_ok_prev_ff <= stop_ok;
    end
  end

  // Events
  always_comb begin
    evt_set = '0;
    evt_set[EVT_ESTOP] = stop_ok_prev_ff && !stop_ok;
    evt_set[EVT_MODE_FAULT] = (nxt_mode == MODE_INVALID) && (mode_ff != MODE_INVALID);
    evt_set[EVT_DROP] = contactor_ff && !nxt_contactor;
    evt_set[EVT_CLOSE] = !contactor_ff && nxt_contactor;
  end

  // APB decode
  assign setup_phase = psel && !penable;
  assign wr_done = psel && penable && pwrite && pready_ff;
  assign hit_ctrl = (paddr[7:0] == OFS_CTRL) && (paddr[ADDR_W-1:8] == '0);
  assign hit_status = (paddr[7:0] == OFS_STATUS) && (paddr[ADDR_W-1:8] == '0);
  assign hit_event = (paddr[7:0] == OFS_EVENT) && (paddr[ADDR_W-1:8] == '0);
  assign hit_mask = (paddr[7:0] == OFS_MASK) && (paddr[ADDR_W-1:8] == '0);

  // A new event in the clearing cycle survives the clear
  assign evt_clr = (wr_done && hit_event) ? pwdata[EVT_N-1:0] : '0;
  assign nxt_event = (event_ff & ~evt_clr) | evt_set;
  // Irq uses the mask written in the same cycle, so it never lags a mask update
  assign nxt_mask = (wr_done && hit_mask) ? pwdata[EVT_N-1:0] : mask_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_ff <= EVT_RST;
    end else if (ce) begin
      event_ff <= nxt_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(nxt_event & nxt_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_ff <= CTRL_PERMIT_RST;
      mask_ff <= MASK_RST;
    end else if (ce && wr_done) begin
      if (hit_ctrl) begin
        permit_ff <= pwdata[CTRL_PERMIT];
      end
      if (hit_mask) begin
        mask_ff <= pwdata[EVT_N-1:0];
      end
    end
  end

  assign status_word = {irq_ff, auto_ff, ready_ff, contactor_ff, mode_ff, sync2_ff};

  // Read data and error are settled in setup, so the access phase has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= setup_phase;
      if (setup_phase) begin
        pslverr_ff <= !(hit_ctrl || hit_status || hit_event || hit_mask);
        prdata_ff <= '0;
        if (!pwrite) begin
          if (hit_ctrl) begin
            prdata_ff[CTRL_PERMIT] <= permit_ff;
          end
          if (hit_status) begin
            prdata_ff[STAT_W-1:0] <= status_word;
          end
          if (hit_event) begin
            prdata_ff[EVT_N-1:0] <= event_ff;
          end
          if (hit_mask) begin
            prdata_ff[EVT_N-1:0] <= mask_ff;
          end
        end
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign drive_power_contactors = contactor_ff;
  assign stop_circuit_ready = ready_ff;
  assign auto_mode = auto_ff;
  assign irq = irq_ff;

  a_estop_drops: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !sync2_ff[PIN_STOP]) |=> (!drive_power_contactors && !stop_circuit_ready)
  ) else $error("contactor stayed on with stop open");

  a_auto_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && sync2_ff[PIN_MODE_A] && !sync2_ff[PIN_MODE_B]) |=> (mode_ff == MODE_AUTO)
  ) else $error("auto pattern not decoded");

  a_manual_decode: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !sync2_ff[PIN_MODE_A] && sync2_ff[PIN_MODE_B]) |=> (mode_ff == MODE_MANUAL)
  ) else $error("manual pattern not decoded");

  a_auto_no_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && nxt_mode == MODE_AUTO && stop_ok && sync2_ff[PIN_DOOR] && sync2_ff[PIN_MPR]
     && permit_ff && !sync2_ff[PIN_ENABLE]) |=> (drive_power_contactors && auto_mode)
  ) else $error("auto mode depended on enable switch");

  a_auto_contactor: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && nxt_mode == MODE_AUTO && !(stop_ok && sync2_ff[PIN_DOOR] && sync2_ff[PIN_MPR]))
    |=> !drive_power_contactors
  ) else $error("auto contactor on without conditions");

  a_manual_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && nxt_mode == MODE_MANUAL && !sync2_ff[PIN_ENABLE]) |=> !stop_circuit_ready
  ) else $error("manual ready without enable switch");

  a_manual_contactor: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && nxt_mode == MODE_MANUAL && stop_ok && !sync2_ff[PIN_DOOR] && sync2_ff[PIN_ENABLE]
     && sync2_ff[PIN_MPR] && permit_ff) |=> drive_power_contactors
  ) else $error("manual contactor failed to close");

  a_power_ready_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !sync2_ff[PIN_MPR]) |=> !drive_power_contactors
  ) else $error("contactor on without power ready");

  a_plug_missing: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !sync2_ff[PIN_PLUG]) |=> (!drive_power_contactors && !stop_circuit_ready)
  ) else $error("open connector did not stop");

  a_ready_indep: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce |=> (stop_circuit_ready == $past(cond_ok) && auto_mode == ($past(cond_ok)
            && mode_ff == MODE_AUTO))
  ) else $error("ready or auto indication wrong");

  a_invalid_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && sync2_ff[PIN_MODE_A] == sync2_ff[PIN_MODE_B])
    |=> (!drive_power_contactors && !stop_circuit_ready && !auto_mode && mode_ff == MODE_INVALID)
  ) else $error("invalid mode left outputs on");

  a_event_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && evt_set[EVT_DROP]) |=> event_ff[EVT_DROP]
  ) else $error("drop event lost");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(ce) |-> (irq == |(event_ff & mask_ff))
  ) else $error("irq disagrees with masked events");

  a_manual_no_auto: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && nxt_mode == MODE_MANUAL) |=> !auto_mode
  ) else $error("auto indication on in manual mode");

  a_permit_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !permit_ff) |=> !drive_power_contactors
  ) else $error("contactor on without software permit");

  a_pready_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && pready) |=> !pready
  ) else $error("pready held past the access cycle");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && setup_phase && !(hit_ctrl || hit_status || hit_event || hit_mask))
    |=> (pready && pslverr)
  ) else $error("unmapped access gave no error");

  a_ce_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> ($stable(drive_power_contactors) && $stable(stop_circuit_ready)
             && $stable(auto_mode) && $stable(irq))
  ) else $error("outputs moved while clock enable was low");

endmodule

// ---- sim/safety_field_model.sv ----
module safety_field_model (
  // Scene chosen by the bench
  input wire logic [1:0] key_pos,
  input wire logic stop_pressed,
  input wire logic door_shut,
  input wire logic [1:0] grip_pos,
  input wire logic power_ok,
  input wire logic plug_in,
  // Pins towards the interlock
  output logic mode_contact_a,
  output logic mode_contact_b,
  output logic stop_pushbutton_closed,
  output logic door_interlock_closed,
  output logic pendant_enable_closed,
  output logic main_power_ready,
  output logic pendant_loop_plug_fitted
);
  timeunit 1ns;
  timeprecision 1ps;
  // Key 0 auto, 1 manual, 2 both open, 3 both closed (a worn or miswired selector)
  assign mode_contact_a = (key_pos == 2'd0) || (key_pos == 2'd3);
  assign mode_contact_b = (key_pos == 2'd1) || (key_pos == 2'd3);
  assign stop_pushbutton_closed = !stop_pressed;
  assign door_interlock_closed = door_shut;
  // Released and fully squeezed both read open, only the middle closes
  assign pendant_enable_closed = (grip_pos == 2'd1);
  assign main_power_ready = power_ok;
  assign pendant_loop_plug_fitted = plug_in;
endmodule

// ---- sim/tb_robot_safety_interlock.sv ----
module tb_robot_safety_interlock;
  timeunit 1ns;
  timeprecision 1ps;
  import interlock_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ma, mb, sc, dc, ec, mpr, pf, cont, rdy, am, stop_p, door_s, pwr_ok, plug;
  logic [1:0] key, grip;
  int n_errors = 0;
  int checks = 0;

  robot_safety_interlock u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_contact_a(ma), .mode_contact_b(mb),
    .stop_pushbutton_closed(sc), .door_interlock_closed(dc), .pendant_enable_closed(ec),
    .main_power_ready(mpr), .pendant_loop_plug_fitted(pf), .drive_power_contactors(cont),
    .stop_circuit_ready(rdy), .auto_mode(am), .irq(irq));

  safety_field_model u_field (.key_pos(key), .stop_pressed(stop_p), .door_shut(door_s),
    .grip_pos(grip), .power_ok(pwr_ok), .plug_in(plug), .mode_contact_a(ma),
    .mode_contact_b(mb), .stop_pushbutton_closed(sc), .door_interlock_closed(dc),
    .pendant_enable_closed(ec), .main_power_ready(mpr), .pendant_loop_plug_fitted(pf));

  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the slave's answer is taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      give_verdict();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns the strobes in this time step
    @(posedge pclk);
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input logic e_err);
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
    check({31'h0, e}, {31'h0, e_err});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] wd);
    logic e;
    apb(1'b1, a, wd, rd, e);
  endtask

  // Set the scene, let the sync and output register settle, then judge ports and status
  task automatic scene(input logic [1:0] k, input logic [4:0] s, input logic pl);
    logic ok, stop_c, en;
    logic [2:0] exp, md;
    logic [31:0] stat;
    key <= k;
    stop_p <= !s[0];
    door_s <= s[1];
    grip <= s[3:2];
    pwr_ok <= s[4];
    plug <= pl;
    repeat (5) @(posedge pclk);
    stop_c = s[0] & pl;
    en = (s[3:2] == 2'd1);
    exp = 3'b000;
    md = MODE_INVALID;
    if (k == 2'd0) begin
      ok = stop_c & s[1];
      exp = {ok, ok, ok & s[4]};
      md = MODE_AUTO;
    end else if (k == 2'd1) begin
      ok = stop_c & !s[1] & en;
      exp = {1'b0, ok, ok & s[4]};
      md = MODE_MANUAL;
    end
    check({29'h0, am, rdy, cont}, {29'h0, exp});
    stat = {18'h0, irq, exp, md, pf, mpr, ec, dc, sc, mb, ma};
    reg_check(OFS_STATUS, stat, 1'b0);
  endtask

  task automatic t_reset_regs();
    reg_check(OFS_CTRL, 32'h0, 1'b0);
    reg_check(OFS_EVENT, 32'h0, 1'b0);
    reg_check(OFS_MASK, 32'h0, 1'b0);
    reg_check(8'h40, 32'h0, 1'b1);
    reg_write(OFS_CTRL, 32'h1);
    reg_check(OFS_CTRL, 32'h1, 1'b0);
  endtask

  task automatic t_mode_tables();
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 32; s++) begin
        scene(k[1:0], s[4:0], 1'b1);
      end
    end
  endtask

  // Stop event from pulling the loop plug: raise, mask, unmask, clear
  task automatic t_plug_irq();
    scene(2'd0, 5'h13, 1'b1);
    reg_write(OFS_EVENT, 32'hf);
    reg_write(OFS_MASK, 32'h1 << EVT_ESTOP);
    check({31'h0, irq}, 32'h0);
    scene(2'd0, 5'h13, 1'b0);
    check({31'h0, irq}, 32'h1);
    reg_check(OFS_EVENT, 32'h1 << EVT_ESTOP | 32'h1 << EVT_DROP, 1'b0);
    reg_write(OFS_MASK, 32'h0);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    reg_write(OFS_MASK, 32'hf);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    reg_write(OFS_EVENT, 32'hf);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
  endtask

  // Clock enable low holds the outputs; release brings mode fault and drop events
  task automatic t_freeze_events();
    scene(2'd0, 5'h13, 1'b1);
    reg_check(OFS_EVENT, 32'h1 << EVT_CLOSE, 1'b0);
    reg_write(OFS_EVENT, 32'hf);
    ce <= 1'b0;
    key <= 2'd3;
    repeat (5) @(posedge pclk);
    check({29'h0, am, rdy, cont}, 32'h7);
    ce <= 1'b1;
    repeat (5) @(posedge pclk);
    check({29'h0, am, rdy, cont}, 32'h0);
    reg_check(OFS_EVENT, 32'h1 << EVT_MODE_FAULT | 32'h1 << EVT_DROP, 1'b0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, stop_p, door_s, pwr_ok, plug} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    key = 2'd2;
    grip = 2'd0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_mode_tables();
    t_plug_irq();
    t_freeze_events();
    give_verdict();
  end
endmodule
